/* verification/serial_flash_pin_interface_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin n_errors++; \
  $display("unexpected %s exp %h seen %h", n, e, s); end end
module serial_flash_pin_interface_bench;
  logic clk_i, srst_i, sclk_i, select_n_i, serial_in_i, serial_out_o, serial_out_oe_o;
  logic reset_n_i, write_protect_n_i, op_valid_o, op_done_i, op_abort_o, rd_req_o;
  logic rd_valid_i, write_latch_flag_o, power_active_o;
  logic [7:0] buf_idx_i, buf_byte_o, rd_data_i, r;
  logic [1:0] protect_bound_o;
  logic [17:0] op_addr_o, rd_addr_o;
  logic [8:0] op_len_o;
  logic [23:0] a;
  logic [31:0] ops[$], got;
  logic [7:0] tq[$], rq[$], d[$];
  sflash_pkg::op_kind_e op_kind_o;
  int n_errors, checks_done, cyc, dcnt, aborts;
  int dly = 6;
  logic [7:0] ec[5] = '{sflash_pkg::CMD_PG_ERASE, sflash_pkg::CMD_SUB_ERASE,
    sflash_pkg::CMD_SECT_ERASE, sflash_pkg::CMD_BULK_ERASE, sflash_pkg::CMD_PG_WRITE};
  sflash_pkg::op_kind_e ek[5] = '{sflash_pkg::OP_PAGE_ERASE, sflash_pkg::OP_SUB_ERASE,
    sflash_pkg::OP_SECT_ERASE, sflash_pkg::OP_BULK_ERASE, sflash_pkg::OP_PAGE_ERASE};
  logic [17:0] em[5] = '{sflash_pkg::PAGE_MASK, sflash_pkg::SUB_MASK, sflash_pkg::SECT_MASK,
    18'h0, sflash_pkg::PAGE_MASK};

  serial_flash_pin_interface dut (.clk_i, .srst_i, .sclk_i, .select_n_i, .serial_in_i,
    .serial_out_o, .serial_out_oe_o, .reset_n_i, .write_protect_n_i, .op_valid_o, .op_kind_o,
    .op_addr_o, .op_len_o, .op_done_i, .op_abort_o, .buf_idx_i, .buf_byte_o, .rd_req_o,
    .rd_addr_o, .rd_valid_i, .rd_data_i, .write_latch_flag_o, .protect_bound_o,
    .power_active_o);
  spi_master_model m (.sclk_o(sclk_i), .select_n_o(select_n_i), .sdi_o(serial_in_i),
    .sdo_i(serial_out_o), .sdo_oe_i(serial_out_oe_o));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // array model: done after dly clocks, read data answered next clock
  always @(posedge clk_i) begin
    #1;
    cyc++;
    if (op_abort_o)
      aborts++;
    if (op_valid_o) begin
      ops.push_back({11'h0, op_kind_o, op_addr_o});
      dcnt = dly;
    end else if (dcnt > 0)
      dcnt--;
    op_done_i = (dcnt == 1);
    rd_valid_i = rd_req_o;
    rd_data_i = rd_addr_o[7:0] ^ 8'h5a;
    if (cyc == 80000) begin
      n_errors++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic cmd(input logic [7:0] op, input bit ad);
    m.sel(1'b1);
    m.xfer(op, r);
    for (int i = 16; ad && i >= 0; i -= 8) m.xfer(a[i+:8], r);
    rq = {};
    foreach (tq[i]) begin
      m.xfer(tq[i], r);
      rq.push_back(r);
    end
    m.sel(1'b0);
    tq = {};
    clks(60);
  endtask
  task automatic chk_op(input sflash_pkg::op_kind_e k, input logic [17:0] ea);
    got = ops.size() ? ops.pop_front() : '1;
    `CHK("op", {11'h0, k, ea}, got)
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    srst_i = 1'b1;
    reset_n_i = 1'b1;
    write_protect_n_i = 1'b1;
    op_done_i = 1'b0;
    rd_valid_i = 1'b0;
    rd_data_i = 8'h00;
    buf_idx_i = 8'h00;
    void'($urandom(32'h0fbf));
    clks(8);
    srst_i = 1'b0;
    `CHK("oe", 1'b0, serial_out_oe_o)
    `CHK("power", 1'b0, power_active_o)
    cmd(sflash_pkg::CMD_WR_EN, 0);
    m.cpol = 1'b1;
    tq = {8'($urandom)};
    cmd(sflash_pkg::CMD_RD_STAT, 0);
    `CHK("status", 8'h02, rq[0])
    m.cpol = 1'b0;
    cmd(sflash_pkg::CMD_WR_DIS, 0);
    a = $urandom;
    tq = {8'h11};
    cmd(sflash_pkg::CMD_PG_PROG, 1);
    `CHK("ops", 0, ops.size())
    cmd(sflash_pkg::CMD_WR_EN, 0);
    a = $urandom;
    repeat (1 + $urandom % 4) tq.push_back(8'($urandom));
    d = tq;
    cmd(sflash_pkg::CMD_PG_PROG, 1);
    chk_op(sflash_pkg::OP_PROGRAM, a[17:0]);
    `CHK("len", 9'(d.size()), op_len_o)
    `CHK("latch", 1'b0, write_latch_flag_o)
    foreach (d[i]) begin
      buf_idx_i = a[7:0] + 8'(i);
      clks(2);
      `CHK("buf", d[i], buf_byte_o)
    end
    for (int i = 0; i < 5; i++) begin
      cmd(sflash_pkg::CMD_WR_EN, 0);
      a = $urandom;
      if (i == 4)
        tq = {8'($urandom)};
      cmd(ec[i], i != 3);
      chk_op(ek[i], a[17:0] & em[i]);
      if (i == 4)
        chk_op(sflash_pkg::OP_PROGRAM, a[17:0]);
    end
    a = $urandom;
    tq = {8'($urandom), 8'($urandom)};
    cmd(sflash_pkg::CMD_READ, 1);
    foreach (rq[i]) `CHK("rdata", (a[7:0] + 8'(i)) ^ 8'h5a, rq[i])
    // long done latency keeps the erase pending across the reset pulse
    dly = 300;
    cmd(sflash_pkg::CMD_WR_EN, 0);
    cmd(sflash_pkg::CMD_SECT_ERASE, 1);
    reset_n_i = 1'b0;
    clks(10);
    `CHK("abort", 1, aborts)
    `CHK("oe", 1'b0, serial_out_oe_o)
    `CHK("latch", 1'b0, write_latch_flag_o)
    reset_n_i = 1'b1;
    dly = 6;
    ops = {};
    clks(300);
    write_protect_n_i = 1'b0;
    cmd(sflash_pkg::CMD_WR_EN, 0);
    tq = {8'h0c};
    cmd(sflash_pkg::CMD_WR_STAT, 0);
    `CHK("bounds", 2'h0, protect_bound_o)
    write_protect_n_i = 1'b1;
    cmd(sflash_pkg::CMD_WR_EN, 0);
    tq = {8'h0c};
    cmd(sflash_pkg::CMD_WR_STAT, 0);
    `CHK("bounds", 2'h3, protect_bound_o)
    cmd(sflash_pkg::CMD_WR_EN, 0);
    cmd(sflash_pkg::CMD_BULK_ERASE, 0);
    `CHK("ops", 0, ops.size())
    end_sim();
  end
endmodule // serial_flash_pin_interface_bench
`default_nettype wire

/* verification/sflash_pins_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sflash_pins_chk (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic select_n_i,
  input wire logic reset_n_i,
  input wire logic write_protect_n_i,
  input wire logic serial_out_oe_o,
  input wire logic op_valid_o,
  input var sflash_pkg::op_kind_e op_kind_o,
  input wire logic op_abort_o,
  input wire logic write_latch_flag_o,
  input wire logic [1:0] protect_bound_o,
  input wire logic power_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // pins pass two sync flops, so levels are held a few clocks before judging
  sequence desel_s; select_n_i [*6]; endsequence
  sequence sel_s; !select_n_i [*5]; endsequence
  sequence held_rst_s; !reset_n_i [*4]; endsequence
  oe_desel_a: assert property (desel_s |-> !serial_out_oe_o)
    else $error("serial out driven while deselected");
  oe_reset_a: assert property (held_rst_s |-> !serial_out_oe_o)
    else $error("serial out driven in reset");
  latch_reset_a: assert property (held_rst_s |-> !write_latch_flag_o)
    else $error("write latch kept through reset");
  power_sel_a: assert property (sel_s |-> power_active_o)
    else $error("standby while selected");
  abort_cause_a: assert property (op_abort_o |-> !$past(reset_n_i, 2))
    else $error("abort without reset");
  op_pulse_a: assert property (op_valid_o |=> !op_valid_o)
    else $error("op start longer than one clock");
  bound_frozen_a: assert property (!write_protect_n_i [*4] |=> $stable(protect_bound_o))
    else $error("bounds changed while protect pin low");
  erase_end_a: assert property (op_valid_o && op_kind_o != sflash_pkg::OP_PROGRAM
    |-> $past(select_n_i, 2)) else $error("erase started before select rise");
endmodule // sflash_pins_chk
bind serial_flash_pin_interface sflash_pins_chk chk (.clk_i, .srst_i, .select_n_i, .reset_n_i,
  .write_protect_n_i, .serial_out_oe_o, .op_valid_o, .op_kind_o, .op_abort_o,
  .write_latch_flag_o, .protect_bound_o, .power_active_o);
`default_nettype wire

/* verification/spi_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  output logic sclk_o,
  output logic select_n_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  bit cpol;
  initial begin
    sclk_o = 1'b0;
    select_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // select fall opens, rise closes; clock idles at cpol
  task automatic sel(input bit on);
    sclk_o = cpol;
    #40;
    select_n_o = !on;
    #40;
    // idle data line toggles so a stale bit is never trusted
    if (!on)
      sdi_o = !sdi_o;
  endtask
  // whole bytes msb first, data set before each rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk_o = 1'b0;
      sdi_o = tx[i];
      #32;
      sclk_o = 1'b1;
      rx[i] = sdo_oe_i ? sdo_i : 1'bx;
      #32;
    end
    sclk_o = cpol;
  endtask
endmodule // spi_master_model
`default_nettype wire

/* verilog/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  // first stage feeds only the second stage
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // pin_sync
`default_nettype wire

/* verilog/serial_flash_pin_interface.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: read data bit changes after each falling serial clock edge
// R2: command, address, data bits sampled on rising serial clock edges
// R3: select high means deselected and serial output not driven
// R4: deselected with no internal cycle means standby power
// R5: select low means selected, active power, ready for a command
// R6: no command starts until a select falling edge is seen
// R7: hardware reset input high means normal operation
// R8: hardware reset low means reset mode, serial output not driven
// R9: hardware reset during an internal cycle disturbs it; master avoids
// R10: write protect freezes protect bounds; protected area refuses changes
// R11: page write or program takes 1 to 256 data bytes
// R12: page write runs page erase then page program
// R13: 2-megabit array: 4 sectors of 256 pages of 256 bytes
// R14: 1-megabit array: 2 sectors of 256 pages of 256 bytes
// R15: page, subsector, sector and bulk erase commands exist
// R16: protection per 64KB sector, subsector erase per 4KB
// R17: serial clock may idle low or high between transfers
// R18: modifying commands need a multiple of eight clock pulses
// R19: modifying commands need the write latch flag set first
// R20: bytes go msb first; select rising edge ends the command
module serial_flash_pin_interface #(
  parameter bit TWO_MBIT = 1'b1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sclk_i,
  input wire logic select_n_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  input wire logic reset_n_i,
  input wire logic write_protect_n_i,
  output logic op_valid_o,
  output sflash_pkg::op_kind_e op_kind_o,
  output logic [sflash_pkg::ADDR_W-1:0] op_addr_o,
  output logic [8:0] op_len_o,
  input wire logic op_done_i,
  output logic op_abort_o,
  input wire logic [7:0] buf_idx_i,
  output logic [7:0] buf_byte_o,
  output logic rd_req_o,
  output logic [sflash_pkg::ADDR_W-1:0] rd_addr_o,
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_data_i,
  output logic write_latch_flag_o,
  output logic [1:0] protect_bound_o,
  output logic power_active_o
);

  typedef enum logic [2:0] {
    FR_IDLE, FR_OPC, FR_ADDR, FR_DATA, FR_READ, FR_STATUS, FR_WSR, FR_SKIP
  } frame_e;
  typedef enum logic [2:0] {EX_IDLE, EX_DRAIN, EX_ERASE, EX_LAST} exec_e;

  localparam logic [sflash_pkg::ADDR_W-1:0] AMASK =
    TWO_MBIT ? sflash_pkg::MASK_2M : sflash_pkg::MASK_1M;
  localparam logic [2:0] SECTORS =
    TWO_MBIT ? 3'(sflash_pkg::SECTORS_2M) : 3'(sflash_pkg::SECTORS_1M);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic takes_addr(input logic [7:0] op);
    takes_addr = (op == sflash_pkg::CMD_READ) | (op == sflash_pkg::CMD_PG_WRITE) |
      (op == sflash_pkg::CMD_PG_PROG) | (op == sflash_pkg::CMD_PG_ERASE) |
      (op == sflash_pkg::CMD_SUB_ERASE) | (op == sflash_pkg::CMD_SECT_ERASE);
  endfunction

  function automatic logic is_page_data(input logic [7:0] op);
    is_page_data = (op == sflash_pkg::CMD_PG_WRITE) | (op == sflash_pkg::CMD_PG_PROG);
  endfunction

  // bounds 0..3 cover 0, 1, 2 or all top sectors
  function automatic logic in_protected(input logic [sflash_pkg::ADDR_W-1:0] a,
                                        input logic [1:0] b);
    logic [2:0] n;
    logic [2:0] sec;
    n = (b == 2'h0) ? 3'h0 : (b == 2'h3) ? SECTORS : (3'h1 << (b - 2'h1));
    n = (n > SECTORS) ? SECTORS : n;
    sec = 3'(a[sflash_pkg::ADDR_W-1:sflash_pkg::SECTOR_LSB]);
    in_protected = (n != 3'h0) & (sec >= SECTORS - n);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edges

  logic [4:0] pin_s;
  logic sclk_s, sel_s, sin_s, hw_n_s, wp_n_s;
  logic sclk_q, sel_q, hw_n_q;
  logic rise, fall, cs_fall, cs_rise, rst_all;

  pin_sync #(.WIDTH(5), .RST_VAL(sflash_pkg::PIN_RST)) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i({sclk_i, select_n_i, serial_in_i, reset_n_i, write_protect_n_i}),
    .q_o(pin_s)
  );

  assign sclk_s = pin_s[4];
  assign sel_s = ~pin_s[3];
  assign sin_s = pin_s[2];
  assign hw_n_s = pin_s[1];
  assign wp_n_s = pin_s[0];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sclk_q <= 1'b0;
      sel_q <= 1'b0;
      hw_n_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
      sel_q <= sel_s;
      hw_n_q <= hw_n_s;
    end
  end

  // R17 either idle level
  // both edges are found by level change, so idle level does not matter
  assign rise = sclk_s & ~sclk_q & sel_s;
  assign fall = ~sclk_s & sclk_q & sel_s;
  assign cs_fall = sel_s & ~sel_q;
  assign cs_rise = ~sel_s & sel_q;
  // R7 normal when high
  // R8 reset mode when low
  assign rst_all = srst_i | ~hw_n_s;

  ////////////////////////////////////////////////////////////////////////
  // serial receive

  frame_e fr_q, fr_d;
  exec_e ex_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q, rx_byte, opc_q;
  logic [1:0] acnt_q;
  logic [23:0] addr_q;
  logic [8:0] dcnt_q;
  logic ovf_q, addr_ok_q, wsr_ok_q;
  logic [1:0] wsr_q, bound_q;
  logic byte_done, busy, push, fifo_in_ready;

  assign busy = (ex_q != EX_IDLE);
  // R20 msb first
  assign rx_byte = {sh_q[6:0], sin_s};
  assign byte_done = rise & (bit_q == 3'h7) & (fr_q != FR_IDLE);
  assign push = byte_done & (fr_q == FR_DATA);

  always_comb begin
    fr_d = fr_q;
    case (fr_q)
      FR_OPC: begin
        if (busy & (rx_byte != sflash_pkg::CMD_RD_STAT)) begin
          fr_d = FR_SKIP;
        end else if (takes_addr(rx_byte)) begin
          fr_d = FR_ADDR;
        end else if (rx_byte == sflash_pkg::CMD_RD_STAT) begin
          fr_d = FR_STATUS;
        end else if (rx_byte == sflash_pkg::CMD_WR_STAT) begin
          fr_d = FR_WSR;
        end else begin
          fr_d = FR_SKIP;
        end
      end
      FR_ADDR: begin
        if (acnt_q == 2'(sflash_pkg::ADDR_BYTES - 1)) begin
          if (opc_q == sflash_pkg::CMD_READ) begin
            fr_d = FR_READ;
          end else if (is_page_data(opc_q)) begin
            fr_d = FR_DATA;
          end else begin
            fr_d = FR_SKIP;
          end
        end
      end
      FR_WSR: fr_d = FR_SKIP;
      default: fr_d = fr_q;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      fr_q <= FR_IDLE;
    end else if (!sel_s) begin
      fr_q <= FR_IDLE;
    // R6 select edge arms
    // only a seen select fall opens a frame, so select low through a pin reset is idle
    end else if (cs_fall) begin
      fr_q <= FR_OPC;
    end else if (byte_done) begin
      fr_q <= fr_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_all | cs_fall) begin
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      acnt_q <= 2'h0;
      dcnt_q <= 9'h000;
      ovf_q <= 1'b0;
      addr_ok_q <= 1'b0;
      wsr_ok_q <= 1'b0;
    // R2 sample on rise
    end else if (rise) begin
      bit_q <= bit_q + 3'h1;
      sh_q <= rx_byte;
      if (byte_done & (fr_q == FR_ADDR)) begin
        acnt_q <= acnt_q + 2'h1;
        addr_ok_q <= (acnt_q == 2'(sflash_pkg::ADDR_BYTES - 1));
      end
      // R11 up to 256
      if (push & (dcnt_q != 9'(sflash_pkg::PAGE_BYTES))) begin
        dcnt_q <= dcnt_q + 9'h001;
      end
      // a full fifo loses the byte, so the command is refused later
      if (push & ~fifo_in_ready) begin
        ovf_q <= 1'b1;
      end
      if (byte_done & (fr_q == FR_WSR)) begin
        wsr_ok_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      opc_q <= 8'h00;
      addr_q <= 24'h000000;
      wsr_q <= 2'h0;
    end else if (byte_done) begin
      if (fr_q == FR_OPC) begin
        opc_q <= rx_byte;
      end
      if (fr_q == FR_ADDR) begin
        addr_q <= {addr_q[15:0], rx_byte};
      end
      if (fr_q == FR_WSR) begin
        wsr_q <= {rx_byte[sflash_pkg::ST_BOUND_HI], rx_byte[sflash_pkg::ST_BOUND_LO]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command acceptance at select rise

  logic [sflash_pkg::ADDR_W-1:0] cmd_addr;
  logic whole, cmd_ok, accept, exec_go, wsr_go, wel_q, last_done;

  assign cmd_addr = addr_q[sflash_pkg::ADDR_W-1:0] & AMASK;
  // R18 whole bytes only
  assign whole = (bit_q == 3'h0);

  // R10 protected area
  // R16 sector granularity
  always_comb begin
    case (opc_q)
      sflash_pkg::CMD_PG_WRITE, sflash_pkg::CMD_PG_PROG:
        cmd_ok = addr_ok_q & (dcnt_q != 9'h000) & ~ovf_q & ~in_protected(cmd_addr, bound_q);
      sflash_pkg::CMD_PG_ERASE, sflash_pkg::CMD_SUB_ERASE, sflash_pkg::CMD_SECT_ERASE:
        cmd_ok = addr_ok_q & ~in_protected(cmd_addr, bound_q);
      sflash_pkg::CMD_BULK_ERASE: cmd_ok = (bound_q == 2'h0);
      sflash_pkg::CMD_WR_STAT: cmd_ok = wsr_ok_q & wp_n_s;
      default: cmd_ok = 1'b0;
    endcase
  end

  // R20 select rise ends
  // R19 latch required
  assign accept = cs_rise & (fr_q != FR_IDLE) & whole & wel_q & ~busy & cmd_ok;
  assign wsr_go = accept & (opc_q == sflash_pkg::CMD_WR_STAT);
  assign exec_go = accept & (opc_q != sflash_pkg::CMD_WR_STAT);
  assign last_done = (ex_q == EX_LAST) & op_done_i;

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      wel_q <= 1'b0;
    end else if (cs_rise & (fr_q != FR_IDLE) & whole & ~busy &
                 (opc_q == sflash_pkg::CMD_WR_EN)) begin
      wel_q <= 1'b1;
    end else if ((cs_rise & (fr_q != FR_IDLE) & whole & ~busy &
                  (opc_q == sflash_pkg::CMD_WR_DIS)) | wsr_go | last_done) begin
      wel_q <= 1'b0;
    end
  end

  // R10 frozen when low
  // bounds are kept through a pin reset, as the stored bits would be
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bound_q <= sflash_pkg::BOUND_RST;
    end else if (wsr_go) begin
      bound_q <= wsr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data fifo and page buffer

  logic fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [7:0] pbuf [sflash_pkg::PAGE_BYTES];
  logic [7:0] widx_q;

  sflash_fifo #(.WIDTH(8), .DEPTH(sflash_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rx_byte),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  // the buffer is frozen while the array engine may be reading it
  assign fifo_out_ready = (ex_q == EX_IDLE) | (ex_q == EX_DRAIN);

  always_ff @(posedge clk_i) begin
    if (fifo_out_valid & fifo_out_ready) begin
      pbuf[widx_q] <= fifo_out_data;
    end
    buf_byte_o <= pbuf[buf_idx_i];
  end

  // R11 wraps in page
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      widx_q <= 8'h00;
    end else if (byte_done & (fr_q == FR_ADDR) & (fr_d == FR_DATA)) begin
      widx_q <= rx_byte;
    end else if (fifo_out_valid & fifo_out_ready) begin
      widx_q <= widx_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // internal cycle sequencing

  logic pend_pw_q;

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      ex_q <= EX_IDLE;
      op_valid_o <= 1'b0;
      op_kind_o <= sflash_pkg::OP_PROGRAM;
      op_addr_o <= '0;
      op_len_o <= 9'h000;
      pend_pw_q <= 1'b0;
    end else begin
      op_valid_o <= 1'b0;
      case (ex_q)
        EX_IDLE: begin
          if (exec_go) begin
            pend_pw_q <= (opc_q == sflash_pkg::CMD_PG_WRITE);
            op_len_o <= dcnt_q;
            // R15 erase kinds
            // R13 array size
            // R14 array size
            case (opc_q)
              sflash_pkg::CMD_PG_ERASE: begin
                op_kind_o <= sflash_pkg::OP_PAGE_ERASE;
                op_addr_o <= cmd_addr & sflash_pkg::PAGE_MASK;
              end
              sflash_pkg::CMD_SUB_ERASE: begin
                op_kind_o <= sflash_pkg::OP_SUB_ERASE;
                op_addr_o <= cmd_addr & sflash_pkg::SUB_MASK;
              end
              sflash_pkg::CMD_SECT_ERASE: begin
                op_kind_o <= sflash_pkg::OP_SECT_ERASE;
                op_addr_o <= cmd_addr & sflash_pkg::SECT_MASK;
              end
              sflash_pkg::CMD_BULK_ERASE: begin
                op_kind_o <= sflash_pkg::OP_BULK_ERASE;
                op_addr_o <= '0;
              end
              default: op_addr_o <= cmd_addr;
            endcase
            op_valid_o <= ~is_page_data(opc_q);
            ex_q <= is_page_data(opc_q) ? EX_DRAIN : EX_LAST;
          end
        end
        EX_DRAIN: begin
          if (!fifo_out_valid) begin
            op_valid_o <= 1'b1;
            // R12 erase then program
            if (pend_pw_q) begin
              op_kind_o <= sflash_pkg::OP_PAGE_ERASE;
              op_addr_o <= op_addr_o & sflash_pkg::PAGE_MASK;
              ex_q <= EX_ERASE;
            end else begin
              op_kind_o <= sflash_pkg::OP_PROGRAM;
              ex_q <= EX_LAST;
            end
          end
        end
        EX_ERASE: begin
          if (op_done_i) begin
            op_valid_o <= 1'b1;
            op_kind_o <= sflash_pkg::OP_PROGRAM;
            op_addr_o <= cmd_addr;
            ex_q <= EX_LAST;
          end
        end
        EX_LAST: begin
          if (op_done_i) begin
            ex_q <= EX_IDLE;
          end
        end
        default: ex_q <= EX_IDLE;
      endcase
    end
  end

  // R9 abort on reset
  // the array engine is told; data in the running cycle may be lost
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      op_abort_o <= 1'b0;
    end else begin
      op_abort_o <= hw_n_q & ~hw_n_s & busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial transmit

  logic [7:0] tx_q, nxt_q, status, load;
  logic tx_on;

  assign status = (8'(bound_q[1]) << sflash_pkg::ST_BOUND_HI) |
                  (8'(bound_q[0]) << sflash_pkg::ST_BOUND_LO) |
                  (8'(wel_q) << sflash_pkg::ST_LATCH) | (8'(busy) << sflash_pkg::ST_BUSY);
  assign tx_on = (fr_q == FR_READ) | (fr_q == FR_STATUS);
  assign load = (fr_q == FR_STATUS) ? status : nxt_q;

  // the array must answer a read request within four clocks
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      rd_req_o <= 1'b0;
      rd_addr_o <= '0;
      nxt_q <= 8'h00;
    end else begin
      rd_req_o <= 1'b0;
      if (byte_done & (fr_q == FR_ADDR) & (fr_d == FR_READ)) begin
        rd_addr_o <= {addr_q[sflash_pkg::ADDR_W-9:0], rx_byte} & AMASK;
        rd_req_o <= 1'b1;
      end else if (fall & (fr_q == FR_READ) & (bit_q == 3'h0)) begin
        rd_addr_o <= (rd_addr_o + 1'b1) & AMASK;
        rd_req_o <= 1'b1;
      end
      if (rd_valid_i) begin
        nxt_q <= rd_data_i;
      end
    end
  end

  // R1 change after fall
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      tx_q <= 8'h00;
      serial_out_o <= 1'b0;
    end else if (fall & tx_on) begin
      if (bit_q == 3'h0) begin
        serial_out_o <= load[7];
        tx_q <= {load[6:0], 1'b0};
      end else begin
        serial_out_o <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // R3 released when deselected
  // R8 released in reset
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      serial_out_oe_o <= 1'b0;
    end else begin
      serial_out_oe_o <= sel_s & tx_on;
    end
  end

  // R4 standby when idle
  // R5 active when selected
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      power_active_o <= 1'b0;
    end else begin
      power_active_o <= sel_s | busy;
    end
  end

  assign write_latch_flag_o = wel_q;
  assign protect_bound_o = bound_q;

endmodule // serial_flash_pin_interface
`default_nettype wire

/* verilog/sflash_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module sflash_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_q];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sflash_fifo
`default_nettype wire

/* verilog/sflash_pkg.sv */
package sflash_pkg;

  ////////////////////////////////////////////////////////////////////////
  // array organisation
  localparam int unsigned PAGE_BYTES = 256;
  localparam int unsigned SECTOR_PAGES = 256;
  localparam int unsigned PAGES_2M = 1024;
  localparam int unsigned PAGES_1M = 512;
  localparam int unsigned SECTORS_2M = 4;
  localparam int unsigned SECTORS_1M = 2;
  localparam int unsigned SECTOR_BYTES = 65536;
  localparam int unsigned SUBSECTOR_BYTES = 4096;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned SECTOR_LSB = 16;
  localparam int unsigned ADDR_BYTES = 3;
  localparam int unsigned FIFO_DEPTH = 16;

  localparam logic [ADDR_W-1:0] MASK_2M = ADDR_W'(PAGES_2M * PAGE_BYTES - 1);
  localparam logic [ADDR_W-1:0] MASK_1M = ADDR_W'(PAGES_1M * PAGE_BYTES - 1);
  localparam logic [ADDR_W-1:0] PAGE_MASK = ~ADDR_W'(PAGE_BYTES - 1);
  localparam logic [ADDR_W-1:0] SUB_MASK = ~ADDR_W'(SUBSECTOR_BYTES - 1);
  localparam logic [ADDR_W-1:0] SECT_MASK = ~ADDR_W'(SECTOR_BYTES - 1);

  ////////////////////////////////////////////////////////////////////////
  // command codes
  localparam logic [7:0] CMD_WR_EN = 8'h06;
  localparam logic [7:0] CMD_WR_DIS = 8'h04;
  localparam logic [7:0] CMD_RD_STAT = 8'h05;
  localparam logic [7:0] CMD_WR_STAT = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_PG_WRITE = 8'h0a;
  localparam logic [7:0] CMD_PG_PROG = 8'h02;
  localparam logic [7:0] CMD_PG_ERASE = 8'hdb;
  localparam logic [7:0] CMD_SUB_ERASE = 8'h20;
  localparam logic [7:0] CMD_SECT_ERASE = 8'hd8;
  localparam logic [7:0] CMD_BULK_ERASE = 8'hc7;

  ////////////////////////////////////////////////////////////////////////
  // status byte layout and reset values
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_LATCH = 1;
  localparam int unsigned ST_BOUND_LO = 2;
  localparam int unsigned ST_BOUND_HI = 3;
  localparam logic [1:0] BOUND_RST = 2'h0;
  // sclk, select_n, serial_in, reset_n, write_protect_n
  localparam logic [4:0] PIN_RST = 5'h0b;

  typedef enum logic [2:0] {
    OP_PROGRAM,
    OP_PAGE_ERASE,
    OP_SUB_ERASE,
    OP_SECT_ERASE,
    OP_BULK_ERASE
  } op_kind_e;

endpackage
